/* File: gpio_pkg.sv */
// constants, register map and carrier types for the port j/k/l pin logic
package gpio_pkg;

  // ==========================================================================
  // register map (halfword addresses on the peripheral bus)
  // ==========================================================================
  localparam logic [31:0] PORT_L_OUTPUT_LATCH_ADDR = 32'hFFFFF75E;
  localparam logic [31:0] PORT_K_OUTPUT_LATCH_ADDR = 32'hFFFFF778;
  localparam logic [31:0] PORT_J_PIN_LEVELS_ADDR   = 32'hFFFFF786;
  localparam logic [31:0] PORT_L_PIN_LEVELS_ADDR   = 32'hFFFFF788;

  // ==========================================================================
  // widths and field positions
  // ==========================================================================
  localparam int unsigned REG_W      = 16;
  localparam int unsigned PORT_J_W   = 16;
  localparam int unsigned PORT_K_W   = 16;
  localparam int unsigned PORT_L_W   = 14;
  localparam int unsigned ADDR_PIN_W = 21;
  localparam int unsigned DATA_PIN_W = 16;
  localparam int unsigned BUS_PIN_W  = ADDR_PIN_W + DATA_PIN_W;

  // byte lanes of a 16-bit register
  localparam int unsigned LANE_LO_LSB = 0;
  localparam int unsigned LANE_LO_MSB = 7;
  localparam int unsigned LANE_HI_LSB = 8;
  localparam int unsigned LANE_HI_MSB = 15;
  localparam int unsigned BE_LO       = 0;
  localparam int unsigned BE_HI       = 1;

  // port l upper bits are reserved
  localparam int unsigned PORT_L_RSVD_LSB = 14;
  localparam int unsigned PORT_L_RSVD_MSB = 15;
  localparam int unsigned PORT_L_TOP_BIT  = 13;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [15:0] LATCH_RESET   = 16'h0000;
  localparam logic [15:0] RDATA_IDLE    = 16'h0000;
  localparam logic [1:0]  PORT_L_RSVD_V = 2'h0;

  // ==========================================================================
  // carrier types
  // ==========================================================================
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic [1:0]  be;
    logic        we;
    logic        re;
  } reg_req_t;

  typedef struct packed {
    logic [BUS_PIN_W-1:0] data;
    logic [BUS_PIN_W-1:0] gpio_out_sel;
  } bus_gpio_t;

endpackage

/* File: pin_level_sync.sv */
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns

module pin_level_sync #(
  parameter int unsigned WIDTH = 16
) (
  // clock and freeze
  input  wire logic             clock_i,
  input  wire logic             ce_i,
  // pin levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // ==========================================================================
  // stages
  // ==========================================================================
  logic [WIDTH-1:0] meta_q;

  // no reset on purpose: the levels follow the pins from the first edges on
  always_ff @(posedge clock_i) begin
    if (ce_i) begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

/* File: gpio_ports_pin_readback_pod.sv */
// port j pin levels, port k latch, port l latch and pin levels, bus output disable
`timescale 1ns/1ns

module gpio_ports_pin_readback_pod (
  // clock, reset, freeze
  input  wire logic                                clock_i,
  input  wire logic                                srst_i,
  input  wire logic                                ce_i,
  // register port
  input  wire gpio_pkg::reg_req_t                  req_i,
  output logic      [gpio_pkg::REG_W-1:0]          rdata_o,
  // port j pins
  input  wire logic [gpio_pkg::PORT_J_W-1:0]       port_j_pin_i,
  // port k pins and pin function controls
  input  wire logic [gpio_pkg::PORT_K_W-1:0]       port_k_pin_i,
  input  wire logic [gpio_pkg::PORT_K_W-1:0]       port_k_direction_bit_i,
  input  wire logic [gpio_pkg::PORT_K_W-1:0]       port_k_gpio_sel_i,
  output logic      [gpio_pkg::PORT_K_W-1:0]       port_k_pin_o,
  output logic      [gpio_pkg::PORT_K_W-1:0]       port_k_pin_oe_o,
  // port l pins and pin function controls
  input  wire logic [gpio_pkg::PORT_L_W-1:0]       port_l_pin_i,
  input  wire logic [gpio_pkg::PORT_L_W-1:0]       port_l_direction_bit_i,
  input  wire logic [gpio_pkg::PORT_L_W-1:0]       port_l_gpio_sel_i,
  output logic      [gpio_pkg::PORT_L_W-1:0]       port_l_pin_o,
  output logic      [gpio_pkg::PORT_L_W-1:0]       port_l_pin_oe_o,
  // address and data bus pins used as general outputs
  input  wire logic                                bus_output_disable_pin_n_i,
  input  wire gpio_pkg::bus_gpio_t                 bus_gpio_i,
  output logic      [gpio_pkg::BUS_PIN_W-1:0]      bus_pin_o,
  output logic      [gpio_pkg::BUS_PIN_W-1:0]      bus_pin_oe_o
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  logic [gpio_pkg::REG_W-1:0]     port_k_output_latch_q;
  logic [gpio_pkg::PORT_L_W-1:0]  port_l_latch_bits_q;
  logic [gpio_pkg::PORT_J_W-1:0]  port_j_level_bits;
  logic [gpio_pkg::PORT_K_W-1:0]  port_k_pin_sync;
  logic [gpio_pkg::PORT_L_W-1:0]  port_l_level_bits;
  logic [gpio_pkg::REG_W-1:0]     port_j_pin_levels;
  logic [gpio_pkg::REG_W-1:0]     port_l_pin_levels;
  logic [gpio_pkg::REG_W-1:0]     port_l_output_latch;
  logic [gpio_pkg::PORT_K_W-1:0]  port_k_read;
  logic [gpio_pkg::PORT_L_W-1:0]  port_l_read;
  logic [gpio_pkg::REG_W-1:0]     rdata_d;
  logic                           hit_j_pins;
  logic                           hit_k_latch;
  logic                           hit_l_latch;
  logic                           hit_l_pins;
  logic                           wr_lo;
  logic                           wr_hi;

  // ==========================================================================
  // pin level synchronisers
  // ==========================================================================
  // pins may change at any time; only the second stage reaches the read path
  pin_level_sync #(
    .WIDTH   (gpio_pkg::PORT_J_W)
  ) u_sync_j (
    .clock_i (clock_i),
    .ce_i    (ce_i),
    .async_i (port_j_pin_i),
    .sync_o  (port_j_level_bits)
  );

  pin_level_sync #(
    .WIDTH   (gpio_pkg::PORT_K_W)
  ) u_sync_k (
    .clock_i (clock_i),
    .ce_i    (ce_i),
    .async_i (port_k_pin_i),
    .sync_o  (port_k_pin_sync)
  );

  pin_level_sync #(
    .WIDTH   (gpio_pkg::PORT_L_W)
  ) u_sync_l (
    .clock_i (clock_i),
    .ce_i    (ce_i),
    .async_i (port_l_pin_i),
    .sync_o  (port_l_level_bits)
  );

  // ==========================================================================
  // address decode
  // ==========================================================================
  // halfword registers: address bit 0 is ignored, lanes pick the byte
  assign hit_j_pins  = req_i.addr[31:1] == gpio_pkg::PORT_J_PIN_LEVELS_ADDR[31:1];
  assign hit_k_latch = req_i.addr[31:1] == gpio_pkg::PORT_K_OUTPUT_LATCH_ADDR[31:1];
  assign hit_l_latch = req_i.addr[31:1] == gpio_pkg::PORT_L_OUTPUT_LATCH_ADDR[31:1];
  assign hit_l_pins  = req_i.addr[31:1] == gpio_pkg::PORT_L_PIN_LEVELS_ADDR[31:1];

  assign wr_lo = ce_i && req_i.we && req_i.be[gpio_pkg::BE_LO];
  assign wr_hi = ce_i && req_i.we && req_i.be[gpio_pkg::BE_HI];

  // ==========================================================================
  // port k output latch
  // ==========================================================================
  // stored on every write whatever the pin function; only the pin driver and the read
  // selection look at direction. srst_i stands for power-on and hardware standby clearing.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      port_k_output_latch_q <= gpio_pkg::LATCH_RESET;
    end else if (hit_k_latch) begin
      if (wr_lo) begin
        port_k_output_latch_q[gpio_pkg::LANE_LO_MSB:gpio_pkg::LANE_LO_LSB]
          <= req_i.wdata[gpio_pkg::LANE_LO_MSB:gpio_pkg::LANE_LO_LSB];
      end
      if (wr_hi) begin
        port_k_output_latch_q[gpio_pkg::LANE_HI_MSB:gpio_pkg::LANE_HI_LSB]
          <= req_i.wdata[gpio_pkg::LANE_HI_MSB:gpio_pkg::LANE_HI_LSB];
      end
    end
  end

  // ==========================================================================
  // port l output latch
  // ==========================================================================
  // reserved bits 15:14 are not stored, so a stray write cannot show up
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      port_l_latch_bits_q <= gpio_pkg::LATCH_RESET[gpio_pkg::PORT_L_W-1:0];
    end else if (hit_l_latch) begin
      if (wr_lo) begin
        port_l_latch_bits_q[gpio_pkg::LANE_LO_MSB:gpio_pkg::LANE_LO_LSB]
          <= req_i.wdata[gpio_pkg::LANE_LO_MSB:gpio_pkg::LANE_LO_LSB];
      end
      if (wr_hi) begin
        port_l_latch_bits_q[gpio_pkg::PORT_L_TOP_BIT:gpio_pkg::LANE_HI_LSB]
          <= req_i.wdata[gpio_pkg::PORT_L_TOP_BIT:gpio_pkg::LANE_HI_LSB];
      end
    end
  end

  // ==========================================================================
  // read selection per bit
  // ==========================================================================
  for (genvar b = 0; b < gpio_pkg::PORT_K_W; b++) begin : g_k_read
    assign port_k_read[b] = port_k_direction_bit_i[b] ? port_k_output_latch_q[b]
                                                      : port_k_pin_sync[b];
  end

  for (genvar b = 0; b < gpio_pkg::PORT_L_W; b++) begin : g_l_read
    assign port_l_read[b] = port_l_direction_bit_i[b] ? port_l_latch_bits_q[b]
                                                      : port_l_level_bits[b];
  end

  assign port_j_pin_levels   = port_j_level_bits;
  assign port_l_pin_levels   = {gpio_pkg::PORT_L_RSVD_V, port_l_level_bits};
  assign port_l_output_latch = {gpio_pkg::PORT_L_RSVD_V, port_l_read};

  // ==========================================================================
  // read data
  // ==========================================================================
  // pin level registers have no write path at all, so writes fall away
  always_comb begin
    rdata_d = gpio_pkg::RDATA_IDLE;
    if (req_i.re) begin
      if (hit_j_pins) begin
        rdata_d = port_j_pin_levels;
      end else if (hit_k_latch) begin
        rdata_d = port_k_read;
      end else if (hit_l_latch) begin
        rdata_d = port_l_output_latch;
      end else if (hit_l_pins) begin
        rdata_d = port_l_pin_levels;
      end
    end
  end

  // whole halfword returned for byte reads too; master picks its lane
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_o <= gpio_pkg::RDATA_IDLE;
    end else if (ce_i) begin
      rdata_o <= rdata_d;
    end
  end

  // ==========================================================================
  // port k and l pin drivers
  // ==========================================================================
  // drive only for general output; other functions leave the pin to their owner
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      port_k_pin_o    <= gpio_pkg::LATCH_RESET;
      port_k_pin_oe_o <= gpio_pkg::LATCH_RESET;
    end else if (ce_i) begin
      port_k_pin_o    <= port_k_output_latch_q;
      port_k_pin_oe_o <= port_k_direction_bit_i & port_k_gpio_sel_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      port_l_pin_o    <= gpio_pkg::LATCH_RESET[gpio_pkg::PORT_L_W-1:0];
      port_l_pin_oe_o <= gpio_pkg::LATCH_RESET[gpio_pkg::PORT_L_W-1:0];
    end else if (ce_i) begin
      port_l_pin_o    <= port_l_latch_bits_q;
      port_l_pin_oe_o <= port_l_direction_bit_i & port_l_gpio_sel_i;
    end
  end

  // ==========================================================================
  // bus pin output disable
  // ==========================================================================
  // deliberately unclocked: the disable pin must float the bus pins even with
  // the clock stopped, so it bypasses the synchronisers
  assign bus_pin_o    = bus_gpio_i.data;
  assign bus_pin_oe_o = bus_gpio_i.gpio_out_sel
                      & {gpio_pkg::BUS_PIN_W{bus_output_disable_pin_n_i}};

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge clock_i);
  endclocking

  default disable iff (srst_i);

  sequence s_read(logic hit);
    ce_i && req_i.re && hit;
  endsequence

  sequence s_full_write(logic hit);
    ce_i && req_i.we && hit && (req_i.be == 2'h3);
  endsequence

  property p_j_read;
    s_read(hit_j_pins) |=> rdata_o == $past(port_j_level_bits);
  endproperty
  a_j_read: assert property (p_j_read)
    else $error("port j level read does not match synchronised pins");

  // both synchroniser stages must have been clocked for the three-edge lag
  property p_j_sync_depth;
    (($past(ce_i, 2) && $past(ce_i)) and s_read(hit_j_pins))
      |=> rdata_o == $past(port_j_pin_i, 3);
  endproperty
  a_j_sync_depth: assert property (p_j_sync_depth)
    else $error("port j read does not lag the pins by two stages");

  property p_k_write;
    s_full_write(hit_k_latch) |=> port_k_output_latch_q == $past(req_i.wdata);
  endproperty
  a_k_write: assert property (p_k_write)
    else $error("port k latch did not take the written halfword");

  property p_k_read;
    s_read(hit_k_latch) |=> rdata_o == $past(
      (port_k_output_latch_q & port_k_direction_bit_i)
      | (port_k_pin_sync & ~port_k_direction_bit_i));
  endproperty
  a_k_read: assert property (p_k_read)
    else $error("port k read mixes latch and pins wrongly");

  property p_k_drive;
    ce_i |=> (port_k_pin_oe_o == $past(port_k_direction_bit_i & port_k_gpio_sel_i))
             && (port_k_pin_o == $past(port_k_output_latch_q));
  endproperty
  a_k_drive: assert property (p_k_drive)
    else $error("port k pin driver does not follow latch and function");

  property p_l_write;
    s_full_write(hit_l_latch) |=> port_l_latch_bits_q == $past(req_i.wdata[13:0]);
  endproperty
  a_l_write: assert property (p_l_write)
    else $error("port l latch did not take the written bits");

  property p_l_reserved;
    (s_read(hit_l_latch) or s_read(hit_l_pins)) |=> rdata_o[15:14] == 2'h0;
  endproperty
  a_l_reserved: assert property (p_l_reserved)
    else $error("port l reserved bits read nonzero");

  property p_l_levels;
    s_read(hit_l_pins) |=> rdata_o[13:0] == $past(port_l_level_bits);
  endproperty
  a_l_levels: assert property (p_l_levels)
    else $error("port l level read does not match synchronised pins");

  property p_reset_clear;
    @(posedge clock_i) disable iff (1'b0)
    srst_i |=> (port_k_output_latch_q == 16'h0000) && (port_l_latch_bits_q == 14'h0000)
               && (rdata_o == 16'h0000);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("latches not cleared by reset");

  property p_l_read;
    s_read(hit_l_latch) |=> rdata_o[13:0] == $past(
      (port_l_latch_bits_q & port_l_direction_bit_i)
      | (port_l_level_bits & ~port_l_direction_bit_i));
  endproperty
  a_l_read: assert property (p_l_read)
    else $error("port l read mixes latch and pins wrongly");

  property p_l_drive;
    ce_i |=> (port_l_pin_oe_o == $past(port_l_direction_bit_i & port_l_gpio_sel_i))
             && (port_l_pin_o == $past(port_l_latch_bits_q));
  endproperty
  a_l_drive: assert property (p_l_drive)
    else $error("port l pin driver does not follow latch and function");

  property p_bus_floats;
    !bus_output_disable_pin_n_i |-> bus_pin_oe_o == '0;
  endproperty
  a_bus_floats: assert property (p_bus_floats)
    else $error("bus pins driven while output disable is low");

  property p_bus_drives;
    bus_output_disable_pin_n_i |-> (bus_pin_oe_o == bus_gpio_i.gpio_out_sel)
                                   && (bus_pin_o == bus_gpio_i.data);
  endproperty
  a_bus_drives: assert property (p_bus_drives)
    else $error("selected bus pins not driving their data while enabled");

  property p_idle_read;
    ce_i && !req_i.re |=> rdata_o == 16'h0000;
  endproperty
  a_idle_read: assert property (p_idle_read)
    else $error("read data not idle outside the answer cycle");

endmodule

/* File: board_pins.sv */
// board-side model of port pins: resolves each pin wire from both drivers
`timescale 1ns/1ns

module board_pins #(
  parameter int unsigned W = 16
) (
  // device side of the pins
  input  wire logic [W-1:0] pin_o_i,
  input  wire logic [W-1:0] pin_oe_i,
  // external circuitry drive level
  input  wire logic [W-1:0] ext_i,
  // resolved wire level seen by the device
  output logic      [W-1:0] level_o
);
  // ==========================================================================
  // wire resolution
  // ==========================================================================
  // board drives every pin hard, so a released pin shows the board level
  always_comb begin
    for (int i = 0; i < W; i++) begin
      level_o[i] = pin_oe_i[i] ? pin_o_i[i] : ext_i[i];
    end
  end
endmodule

/* File: tb_top.sv */
// self-checking testbench for the port j/k/l pin logic
`timescale 1ns/1ns

module tb_top;
  // ==========================================================================
  // signals
  // ==========================================================================
  logic                   clock_i = 1'b0;
  logic                   srst_i  = 1'b1;
  logic                   ce_i    = 1'b1;
  gpio_pkg::reg_req_t     req     = '0;
  logic [15:0]            rdata_o;
  logic [15:0]            j_ext   = 16'h0000;
  logic [15:0]            k_ext   = 16'h0000;
  logic [13:0]            l_ext   = 14'h0000;
  logic [15:0]            k_dir   = 16'h0000;
  logic [15:0]            k_sel   = 16'h0000;
  logic [13:0]            l_dir   = 14'h0000;
  logic [13:0]            l_sel   = 14'h0000;
  logic                   disable_n = 1'b1;
  gpio_pkg::bus_gpio_t    bg      = '0;
  logic [15:0]            k_lvl, k_po, k_oe;
  logic [13:0]            l_lvl, l_po, l_oe;
  logic [36:0]            bus_po, bus_oe;
  int                     n_mismatch  = 0;
  int                     check_count = 0;

  always #2 clock_i = ~clock_i;

  gpio_ports_pin_readback_pod i_dut (
    .clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i), .req_i(req), .rdata_o(rdata_o),
    .port_j_pin_i(j_ext),
    .port_k_pin_i(k_lvl), .port_k_direction_bit_i(k_dir), .port_k_gpio_sel_i(k_sel),
    .port_k_pin_o(k_po), .port_k_pin_oe_o(k_oe),
    .port_l_pin_i(l_lvl), .port_l_direction_bit_i(l_dir), .port_l_gpio_sel_i(l_sel),
    .port_l_pin_o(l_po), .port_l_pin_oe_o(l_oe),
    .bus_output_disable_pin_n_i(disable_n), .bus_gpio_i(bg),
    .bus_pin_o(bus_po), .bus_pin_oe_o(bus_oe));

  board_pins #(.W(16)) i_k_board (.pin_o_i(k_po), .pin_oe_i(k_oe), .ext_i(k_ext), .level_o(k_lvl));
  board_pins #(.W(14)) i_l_board (.pin_o_i(l_po), .pin_oe_i(l_oe), .ext_i(l_ext), .level_o(l_lvl));

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge clock_i);
    req.addr  <= a;
    req.wdata <= d;
    req.be    <= be;
    req.we    <= 1'b1;
    @(posedge clock_i);
    req.we    <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [31:0] a, input logic [15:0] exp);
    @(posedge clock_i);
    req.addr <= a;
    req.re   <= 1'b1;
    @(posedge clock_i);
    req.re   <= 1'b0;
    #1;
    chk(what, {48'h0, rdata_o}, {48'h0, exp});
  endtask

  // lets pin changes cross the two-flop synchroniser
  // ends off the edge so that direct output checks see settled values
  task automatic settle();
    repeat (4) @(posedge clock_i);
    #1;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clock_i);
    n_mismatch++;
    summarize();
  end

  // ==========================================================================
  // tests
  // ==========================================================================
  initial begin
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    rd("k latch reset", gpio_pkg::PORT_K_OUTPUT_LATCH_ADDR, 16'h0000);
    rd("l latch reset", gpio_pkg::PORT_L_OUTPUT_LATCH_ADDR, 16'h0000);
    $display("test reset done");

    @(posedge clock_i);
    j_ext <= 16'hA5C3;
    settle();
    rd("j levels", gpio_pkg::PORT_J_PIN_LEVELS_ADDR, 16'hA5C3);
    wr(gpio_pkg::PORT_J_PIN_LEVELS_ADDR, 16'h0F0F, 2'h3);
    rd("j after write", gpio_pkg::PORT_J_PIN_LEVELS_ADDR, 16'hA5C3);
    @(posedge clock_i);
    j_ext <= 16'h5A3C;
    settle();
    rd("j follows pins", gpio_pkg::PORT_J_PIN_LEVELS_ADDR, 16'h5A3C);
    $display("test port j done");

    @(posedge clock_i);
    k_dir <= 16'hFFFF;
    k_sel <= 16'hFFFF;
    k_ext <= 16'h0000;
    wr(gpio_pkg::PORT_K_OUTPUT_LATCH_ADDR, 16'h1234, 2'h3);
    wr(gpio_pkg::PORT_K_OUTPUT_LATCH_ADDR, 16'h00AB, 2'h1);
    settle();
    chk("k pin out", {48'h0, k_po}, 64'h12AB);
    chk("k pin oe", {48'h0, k_oe}, 64'hFFFF);
    rd("k latch", gpio_pkg::PORT_K_OUTPUT_LATCH_ADDR, 16'h12AB);
    wr(gpio_pkg::PORT_K_OUTPUT_LATCH_ADDR, 16'h8000, 2'h2);
    rd("k hi lane", gpio_pkg::PORT_K_OUTPUT_LATCH_ADDR, 16'h80AB);
    @(posedge clock_i);
    k_dir <= 16'h0000;
    k_ext <= 16'h5A5A;
    wr(gpio_pkg::PORT_K_OUTPUT_LATCH_ADDR, 16'hFFFF, 2'h3);
    settle();
    chk("k in oe", {48'h0, k_oe}, 64'h0000);
    rd("k input read", gpio_pkg::PORT_K_OUTPUT_LATCH_ADDR, 16'h5A5A);
    @(posedge clock_i);
    k_dir <= 16'hFFFF;
    k_sel <= 16'h0000;
    settle();
    chk("k other oe", {48'h0, k_oe}, 64'h0000);
    rd("k stored", gpio_pkg::PORT_K_OUTPUT_LATCH_ADDR, 16'hFFFF);
    $display("test port k done");

    @(posedge clock_i);
    l_ext <= 14'h2A5C;
    settle();
    rd("l levels", gpio_pkg::PORT_L_PIN_LEVELS_ADDR, 16'h2A5C);
    rd("l input read", gpio_pkg::PORT_L_OUTPUT_LATCH_ADDR, 16'h2A5C);
    wr(gpio_pkg::PORT_L_OUTPUT_LATCH_ADDR, 16'h3FFF, 2'h3);
    wr(gpio_pkg::PORT_L_PIN_LEVELS_ADDR, 16'h0000, 2'h3);
    settle();
    rd("l levels kept", gpio_pkg::PORT_L_PIN_LEVELS_ADDR, 16'h2A5C);
    @(posedge clock_i);
    l_dir <= 14'h3FFF;
    l_sel <= 14'h3FFF;
    wr(gpio_pkg::PORT_L_OUTPUT_LATCH_ADDR, 16'h01C3, 2'h3);
    settle();
    chk("l pin out", {50'h0, l_po}, 64'h01C3);
    chk("l pin oe", {50'h0, l_oe}, 64'h3FFF);
    rd("l latch", gpio_pkg::PORT_L_OUTPUT_LATCH_ADDR, 16'h01C3);
    rd("l driven levels", gpio_pkg::PORT_L_PIN_LEVELS_ADDR, 16'h01C3);
    $display("test port l done");

    @(posedge clock_i);
    bg.data         <= 37'h15_5555_AAAA;
    bg.gpio_out_sel <= 37'h0F_0F0F_00FF;
    disable_n       <= 1'b0;
    #1;
    chk("bus oe off", {27'h0, bus_oe}, 64'h0);
    chk("bus data", {27'h0, bus_po}, 64'h15_5555_AAAA);
    @(posedge clock_i);
    disable_n <= 1'b1;
    #1;
    chk("bus oe on", {27'h0, bus_oe}, 64'h0F_0F0F_00FF);
    chk("bus data on", {27'h0, bus_po}, 64'h15_5555_AAAA);
    @(posedge clock_i);
    disable_n <= 1'b0;
    // a flop on the disable pin would still show the old enables here
    #1;
    chk("bus oe async", {27'h0, bus_oe}, 64'h0);
    $display("test bus disable done");

    @(posedge clock_i);
    srst_i <= 1'b1;
    @(posedge clock_i);
    srst_i <= 1'b0;
    rd("k latch clear", gpio_pkg::PORT_K_OUTPUT_LATCH_ADDR, 16'h0000);
    rd("l latch clear", gpio_pkg::PORT_L_OUTPUT_LATCH_ADDR, 16'h0000);
    $display("test second reset done");
    summarize();
  end
endmodule
